// File: rtl/scpr_port.sv
// serial configuration port, control registers, readback and offset calibration
module scpr_port #(
	parameter int unsigned WORD_W = 32,
	parameter logic [1:0] ID_CODE = 2'h2 // version code, value arbitrary
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// three-wire serial link and readout pin
	input wire logic i_ser_clk,
	input wire logic i_ser_data,
	input wire logic i_latch_pulse_alt,
	output logic o_readback,
	// parallel fast gain pins
	input wire logic [2:0] i_external_gain,
	// calibration oscillator and offset comparators
	input wire logic i_osc_clk,
	input wire logic i_cmp_i_high,
	input wire logic i_cmp_q_high,
	// analog controls
	output logic o_mixer_off,
	output logic o_test_buffer_off,
	output logic o_filter_off,
	output logic o_cal_logic_off,
	output logic [4:0] o_gain_code,
	output logic [7:0] o_corner_code,
	output logic [1:0] o_det_bw,
	output logic o_output_attenuator_enable,
	output logic [7:0] o_i_offset_code,
	output logic [7:0] o_q_offset_code,
	output logic [1:0] o_cal_reference_current_sel,
	output logic [2:0] o_osc_trim,
	output logic o_cal_busy,
	output logic [31:0] o_mixer_load_filter_mode,
	output logic [31:0] o_bias_trim_ctrl
);
	import scpr_pkg::*;

	// only a 32-bit word matches the field layout
	if (WORD_W != 32) begin : g_chk
		$error("scpr_port: WORD_W must be 32");
	end

	// edge detection on the serial pins (taken as synchronous)
	logic ser_q;
	logic lat_q;
	logic osc_q;
	logic ser_rise;
	logic lat_rise;
	logic osc_rise;
	assign ser_rise = i_ser_clk & ~ser_q;
	assign lat_rise = i_latch_pulse_alt & ~lat_q;
	assign osc_rise = i_osc_clk & ~osc_q;

	// previous pin levels
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ser_q <= 1'b0;
			lat_q <= 1'b0;
			osc_q <= 1'b0;
		end else begin
			ser_q <= i_ser_clk;
			lat_q <= i_latch_pulse_alt;
			osc_q <= i_osc_clk;
		end
	end

	// input shift register
	logic [31:0] shreg;
	logic [31:0] next_shreg;

	// new bit enters at the top, so bit 0 ends up first-sent
	always_comb begin
		next_shreg = shreg;
		if (ser_rise) begin
			next_shreg = {i_ser_data, shreg[31:1]};
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			shreg <= '0;
		end else begin
			shreg <= next_shreg;
		end
	end

	// address decode of the word waiting in the shift register
	logic [2:0] w_reg;
	logic [1:0] w_bank;
	logic commit;
	assign w_reg = shreg[SCPR_ADDR_LSB +: 3];
	assign w_bank = shreg[SCPR_BANK_LSB +: 2];
	assign commit = lat_rise && (w_bank == SCPR_BANK);

	// control registers
	logic [31:0] r1;
	logic [31:0] r2;
	logic [31:0] r3;
	logic [31:0] r5;
	logic [31:0] next_r1;
	logic [31:0] next_r2;
	logic [31:0] next_r3;
	logic [31:0] next_r5;
	logic cal_clear; // start bit self-clear request

	// commit; a host write of the start bit wins over the self-clear
	always_comb begin
		next_r1 = r1;
		next_r2 = r2;
		next_r3 = r3;
		next_r5 = r5;
		if (cal_clear) begin
			next_r2[SCPR_R2_START] = 1'b0;
		end
		if (commit) begin
			case (w_reg)
				SCPR_REG1: next_r1 = shreg;
				SCPR_REG2: next_r2 = shreg;
				SCPR_REG3: next_r3 = shreg;
				SCPR_REG5: next_r5 = shreg;
				// register 4, 0 and others store nothing
				default: next_r1 = r1;
			endcase
		end
	end

	// power-up defaults
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			r1 <= SCPR_R1_RST;
			r2 <= SCPR_R2_RST;
			r3 <= SCPR_R3_RST;
			r5 <= SCPR_R5_RST;
		end else begin
			r1 <= next_r1;
			r2 <= next_r2;
			r3 <= next_r3;
			r5 <= next_r5;
		end
	end

	// static field outputs straight from the registers
	assign o_mixer_off = r1[SCPR_R1_MIX_OFF];
	assign o_test_buffer_off = r1[SCPR_R1_BUF_OFF];
	assign o_filter_off = r1[SCPR_R1_FILT_OFF];
	assign o_cal_logic_off = r1[SCPR_R1_CAL_OFF];
	assign o_corner_code = r1[SCPR_R1_CORNER_LSB +: 8];
	assign o_output_attenuator_enable = r1[SCPR_R1_ATTN];
	assign o_cal_reference_current_sel = r2[SCPR_R2_IREF_LSB +: 2];
	assign o_osc_trim = r2[SCPR_R2_TRIM_LSB +: 3];
	assign o_mixer_load_filter_mode = r3;
	assign o_bias_trim_ctrl = r5;

	// detector bandwidth: resistor bit low bypasses both stages
	always_comb begin
		if (!r1[SCPR_R1_DET_R]) begin
			o_det_bw = SCPR_DETBW_10M;
		end else if (r1[SCPR_R1_DET_C]) begin
			o_det_bw = SCPR_DETBW_1K;
		end else begin
			o_det_bw = SCPR_DETBW_10K;
		end
	end

	// effective gain code
	logic [4:0] prog_gain;
	logic [4:0] ext_w;
	logic [4:0] next_gain;
	assign prog_gain = r1[SCPR_R1_GAIN_LSB +: 5];
	// doubled weight shifts the pin value up by one
	assign ext_w = r1[SCPR_R1_EXT_X2] ? {1'b0, i_external_gain, 1'b0} :
		{2'h0, i_external_gain};

	// subtract with floor at zero; codes above 24 are held at 24
	always_comb begin
		next_gain = prog_gain;
		if (r1[SCPR_R1_EXT_EN]) begin
			next_gain = (ext_w > prog_gain) ? 5'h00 : prog_gain - ext_w;
		end
		if (next_gain > SCPR_GAIN_MAX) begin
			next_gain = SCPR_GAIN_MAX;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_gain_code <= 5'h0F;
		end else begin
			o_gain_code <= next_gain;
		end
	end

	// calibration clock divider
	logic src_tick;
	logic div_tick;
	logic [14:0] div_cnt;
	logic [14:0] next_div_cnt;
	logic [14:0] ratio;
	scpr_cal_state_t cal_st;
	scpr_cal_state_t next_cal_st;
	assign src_tick = r2[SCPR_R2_CLK_SRC] ? osc_rise : ser_rise;
	assign ratio = SCPR_DIV_RATIO[r2[SCPR_R2_DIV_LSB +: 3]];

	// one tick out per ratio ticks in; held at zero when idle
	always_comb begin
		next_div_cnt = div_cnt;
		div_tick = 1'b0;
		if (cal_st != SCPR_CAL_RUN) begin
			next_div_cnt = 15'h0000;
		end else if (src_tick) begin
			if (div_cnt >= ratio - 15'h0001) begin
				next_div_cnt = 15'h0000;
				div_tick = 1'b1;
			end else begin
				next_div_cnt = div_cnt + 15'h0001;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= next_div_cnt;
		end
	end

	// successive approximation of the I and Q offset codes
	logic [2:0] idx;
	logic [2:0] next_idx;
	logic [7:0] try_i;
	logic [7:0] try_q;
	logic [7:0] next_try_i;
	logic [7:0] next_try_q;
	logic [7:0] next_dac_i;
	logic [7:0] next_dac_q;
	logic cal_go;
	logic cal_finish;
	assign cal_go = r2[SCPR_R2_START] && r2[SCPR_R2_CAL_SEL] && !r1[SCPR_R1_CAL_OFF];

	// eight steps per channel, one per divided tick
	always_comb begin
		next_cal_st = cal_st;
		next_idx = idx;
		next_try_i = try_i;
		next_try_q = try_q;
		cal_finish = 1'b0;
		cal_clear = 1'b0;
		case (cal_st)
			SCPR_CAL_IDLE: begin
				if (cal_go) begin
					next_cal_st = SCPR_CAL_RUN;
					next_idx = 3'h7;
					next_try_i = SCPR_DAC_RST;
					next_try_q = SCPR_DAC_RST;
				end else if (r2[SCPR_R2_START]) begin
					// nothing to run in manual mode or with logic off
					cal_clear = 1'b1;
				end
			end
			SCPR_CAL_RUN: begin
				if (!r2[SCPR_R2_CAL_SEL] || r1[SCPR_R1_CAL_OFF]) begin
					next_cal_st = SCPR_CAL_IDLE;
					cal_clear = 1'b1;
				end else if (div_tick) begin
					// comparator high means the trial bit overshoots
					next_try_i[idx] = ~i_cmp_i_high;
					next_try_q[idx] = ~i_cmp_q_high;
					if (idx == 3'h0) begin
						next_cal_st = SCPR_CAL_IDLE;
						cal_finish = 1'b1;
						cal_clear = 1'b1;
					end else begin
						next_idx = idx - 3'h1;
						next_try_i[idx - 3'h1] = 1'b1;
						next_try_q[idx - 3'h1] = 1'b1;
					end
				end
			end
			default: begin
				next_cal_st = SCPR_CAL_IDLE;
			end
		endcase
	end

	// applied codes: trial while running, result in auto, register in manual
	always_comb begin
		next_dac_i = o_i_offset_code;
		next_dac_q = o_q_offset_code;
		if (!r2[SCPR_R2_CAL_SEL]) begin
			next_dac_i = r2[SCPR_R2_I_LSB +: 8];
			next_dac_q = r2[SCPR_R2_Q_LSB +: 8];
		end else if (next_cal_st == SCPR_CAL_RUN || cal_finish) begin
			next_dac_i = next_try_i;
			next_dac_q = next_try_q;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cal_st <= SCPR_CAL_IDLE;
			idx <= 3'h7;
			try_i <= SCPR_DAC_RST;
			try_q <= SCPR_DAC_RST;
			o_i_offset_code <= SCPR_DAC_RST;
			o_q_offset_code <= SCPR_DAC_RST;
		end else begin
			cal_st <= next_cal_st;
			idx <= next_idx;
			try_i <= next_try_i;
			try_q <= next_try_q;
			o_i_offset_code <= next_dac_i;
			o_q_offset_code <= next_dac_q;
		end
	end
	assign o_cal_busy = (cal_st == SCPR_CAL_RUN);

	// readback sequencer
	scpr_rb_state_t rb_st;
	scpr_rb_state_t next_rb_st;
	logic [31:0] snap;
	logic [31:0] next_snap;
	logic [31:0] rb_word;
	logic [4:0] rb_cnt;
	logic [4:0] next_rb_cnt;
	logic rb_bit;
	logic next_rb_bit;
	logic rb_cmd;
	assign rb_cmd = commit && (w_reg == SCPR_REG0) && shreg[SCPR_RB_EN];

	// word chosen by the command; register 0 carries the DAC codes
	always_comb begin
		rb_word = '0;
		case (shreg[SCPR_RB_SEL_LSB +: 3])
			SCPR_REG0: begin
				rb_word[4:0] = SCPR_RB_ADDR;
				rb_word[SCPR_RB_ID_LSB +: 2] = ID_CODE;
				rb_word[SCPR_RB_Q_LSB +: 8] = o_q_offset_code;
				rb_word[SCPR_RB_I_LSB +: 8] = o_i_offset_code;
			end
			SCPR_REG1: rb_word = r1;
			SCPR_REG2: rb_word = r2;
			SCPR_REG3: rb_word = r3;
			SCPR_REG5: rb_word = r5;
			default: rb_word = '0;
		endcase
	end

	// idle clock first, then 32 bits LSB first
	always_comb begin
		next_rb_st = rb_st;
		next_snap = snap;
		next_rb_cnt = rb_cnt;
		next_rb_bit = rb_bit;
		if (rb_cmd) begin
			next_rb_st = SCPR_RB_ARMED;
			next_snap = rb_word;
			next_rb_cnt = 5'h00;
			next_rb_bit = 1'b0;
		end else if (ser_rise) begin
			case (rb_st)
				SCPR_RB_IDLE: next_rb_st = SCPR_RB_IDLE;
				SCPR_RB_ARMED: next_rb_st = SCPR_RB_SHIFT;
				SCPR_RB_SHIFT: begin
					next_rb_bit = snap[rb_cnt];
					next_rb_cnt = rb_cnt + 5'h01;
					if (rb_cnt == SCPR_RB_LAST) begin
						next_rb_st = SCPR_RB_IDLE;
					end
				end
				default: next_rb_st = SCPR_RB_IDLE;
			endcase
		end
	end

	// oscillator test overrides the readout data
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rb_st <= SCPR_RB_IDLE;
			snap <= '0;
			rb_cnt <= 5'h00;
			rb_bit <= 1'b0;
			o_readback <= 1'b0;
		end else begin
			rb_st <= next_rb_st;
			snap <= next_snap;
			rb_cnt <= next_rb_cnt;
			rb_bit <= next_rb_bit;
			o_readback <= r1[SCPR_R1_OSC_TEST] ? i_osc_clk : next_rb_bit;
		end
	end

	// checks
	default clocking scpr_cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	AST_SHIFT_LSB_FIRST: assert property (
		ser_rise |=> shreg[31] == $past(i_ser_data) && shreg[30:0] == $past(shreg[31:1]))
		else $error("shift register did not take the sampled bit at the top");
	AST_R1_COMMIT: assert property (
		lat_rise && w_bank == SCPR_BANK && w_reg == SCPR_REG1 |=> r1 == $past(shreg))
		else $error("register 1 not loaded on latch rise");
	AST_REG4_IGNORED: assert property (
		lat_rise && w_reg == SCPR_REG4 |=> $stable(r1) && $stable(r3) && $stable(r5))
		else $error("write to register 4 changed a register");
	AST_GAIN_FLOOR: assert property (
		r1[SCPR_R1_EXT_EN] && ext_w >= prog_gain && $stable(r1) |=> o_gain_code == 5'h00)
		else $error("effective gain did not floor at zero");
	AST_RB_IDLE_CLOCK: assert property (
		rb_st == SCPR_RB_ARMED && ser_rise && !rb_cmd |=> rb_st == SCPR_RB_SHIFT && rb_cnt == 5'h00)
		else $error("first clock after readback command was not idle");
	AST_RB_FIRST_BIT: assert property (
		rb_st == SCPR_RB_SHIFT && rb_cnt == 5'h00 && ser_rise && !rb_cmd
		&& !r1[SCPR_R1_OSC_TEST] |=> o_readback == snap[0] && rb_cnt == 5'h01)
		else $error("readback did not drive bit 0 first");
	AST_OSC_ON_PIN: assert property (
		r1[SCPR_R1_OSC_TEST] |=> o_readback == $past(i_osc_clk))
		else $error("oscillator not routed to readout pin");
	AST_START_CLEARS: assert property (
		cal_finish && !(commit && w_reg == SCPR_REG2) |=> !r2[SCPR_R2_START] && !o_cal_busy)
		else $error("start bit not cleared after calibration");
	AST_DIV_BY_ONE: assert property (
		o_cal_busy && src_tick && r2[SCPR_R2_DIV_LSB +: 3] == 3'h0 |-> div_tick)
		else $error("divide-by-one ratio skipped a tick");
	AST_MANUAL_DAC: assert property (
		!r2[SCPR_R2_CAL_SEL] |=> o_i_offset_code == $past(r2[SCPR_R2_I_LSB +: 8])
		&& o_q_offset_code == $past(r2[SCPR_R2_Q_LSB +: 8]))
		else $error("manual mode did not apply programmed I and Q codes");

	COV_R2_WRITE: cover property (commit && w_reg == SCPR_REG2);
	COV_RB_DONE: cover property (rb_st == SCPR_RB_SHIFT ##1 rb_st == SCPR_RB_IDLE);
	COV_CAL_DONE: cover property (cal_finish);
	COV_GAIN_FLOOR: cover property (r1[SCPR_R1_EXT_EN] && next_gain == 5'h00);
endmodule

// File: common/scpr_pkg.sv
// constants, field layout and state codes of the serial configuration port
// How it works
// - 32-bit shift register fed by three host lines
// - words arrive LSB first, sampled on clock rise
// - latch rise copies word into addressed register
// - bits 0-2 register, bits 3-4 bank
// - readback is command write then data out
// - readback can return calibrated I/Q DAC codes
// - readout bit driven on each clock rise
// - one idle clock, then 32 data clocks
// - register 4 writes do nothing
// - register 1 power-down bits with defaults
// - five-bit gain code, 0 to 24, default 15
// - eight-bit corner code, default 128
// - detector bandwidth decode from bits 25-26
// - fast gain enable and doubled weight
// - oscillator test output replaces readback data
// - output attenuator enable, default off
// - start bit starts calibration, self-clears
// - manual I/Q DAC codes, reset 0x80
// - reference current select, default 11
// - calibration method select, default automatic
// - calibration clock divider ratio table
// - calibration clock source and oscillator trim
// - effective gain minus external bits, floor 0
package scpr_pkg;
	// address field of a word
	localparam int unsigned SCPR_ADDR_LSB = 0;
	localparam int unsigned SCPR_BANK_LSB = 3;
	localparam logic [1:0] SCPR_BANK = 2'h1;
	localparam logic [2:0] SCPR_REG0 = 3'h0;
	localparam logic [2:0] SCPR_REG1 = 3'h1;
	localparam logic [2:0] SCPR_REG2 = 3'h2;
	localparam logic [2:0] SCPR_REG3 = 3'h3;
	localparam logic [2:0] SCPR_REG4 = 3'h4;
	localparam logic [2:0] SCPR_REG5 = 3'h5;
	// power_gain_filter_ctrl fields
	localparam int unsigned SCPR_R1_MIX_OFF = 5;
	localparam int unsigned SCPR_R1_BUF_OFF = 7;
	localparam int unsigned SCPR_R1_FILT_OFF = 8;
	localparam int unsigned SCPR_R1_CAL_OFF = 10;
	localparam int unsigned SCPR_R1_GAIN_LSB = 12;
	localparam int unsigned SCPR_R1_CORNER_LSB = 17;
	localparam int unsigned SCPR_R1_DET_R = 25;
	localparam int unsigned SCPR_R1_DET_C = 26;
	localparam int unsigned SCPR_R1_EXT_EN = 27;
	localparam int unsigned SCPR_R1_EXT_X2 = 28;
	localparam int unsigned SCPR_R1_OSC_TEST = 29;
	localparam int unsigned SCPR_R1_ATTN = 31;
	// offset_cal_ctrl fields
	localparam int unsigned SCPR_R2_START = 5;
	localparam int unsigned SCPR_R2_I_LSB = 6;
	localparam int unsigned SCPR_R2_Q_LSB = 14;
	localparam int unsigned SCPR_R2_IREF_LSB = 22;
	localparam int unsigned SCPR_R2_CAL_SEL = 24;
	localparam int unsigned SCPR_R2_DIV_LSB = 25;
	localparam int unsigned SCPR_R2_CLK_SRC = 28;
	localparam int unsigned SCPR_R2_TRIM_LSB = 29;
	// readback command and readback word fields
	localparam int unsigned SCPR_RB_EN = 31;
	localparam int unsigned SCPR_RB_SEL_LSB = 28;
	localparam int unsigned SCPR_RB_ID_LSB = 5;
	localparam int unsigned SCPR_RB_Q_LSB = 16;
	localparam int unsigned SCPR_RB_I_LSB = 24;
	localparam logic [4:0] SCPR_RB_ADDR = 5'h08;
	// values after power-up
	localparam logic [31:0] SCPR_R1_RST = 32'h0100FC89;
	localparam logic [31:0] SCPR_R2_RST = 32'h71E0200A;
	localparam logic [31:0] SCPR_R3_RST = 32'h4000000B;
	localparam logic [31:0] SCPR_R5_RST = 32'h0000AAAD;
	localparam logic [7:0] SCPR_DAC_RST = 8'h80;
	// gain limits, readback length
	localparam logic [4:0] SCPR_GAIN_MAX = 5'h18;
	localparam logic [4:0] SCPR_RB_LAST = 5'h1F;
	// calibration divider ratios, index is the 3-bit code
	localparam logic [14:0] SCPR_DIV_RATIO [0:7] = '{15'h0001, 15'h0008, 15'h0010,
		15'h0080, 15'h0100, 15'h0400, 15'h0800, 15'h412C};
	// detector bandwidth codes on the output
	localparam logic [1:0] SCPR_DETBW_10M = 2'h0;
	localparam logic [1:0] SCPR_DETBW_10K = 2'h1;
	localparam logic [1:0] SCPR_DETBW_1K = 2'h2;
	// readback sequencer states
	typedef enum logic [2:0] {
		SCPR_RB_IDLE = 3'h1,
		SCPR_RB_ARMED = 3'h2,
		SCPR_RB_SHIFT = 3'h4
	} scpr_rb_state_t;
	// calibration sequencer states
	typedef enum logic [1:0] {
		SCPR_CAL_IDLE = 2'h1,
		SCPR_CAL_RUN = 2'h2
	} scpr_cal_state_t;
endpackage

// File: sim/scpr_host_model.sv
// host controller model that drives the serial port and captures the readout pin
module scpr_host_model (
	// clock
	input wire logic i_clk,
	// readout pin from the device
	input wire logic i_readback,
	// serial lines towards the device
	output logic o_ser_clk,
	output logic o_ser_data,
	output logic o_latch
);
	timeunit 1ns;
	timeprecision 100ps;
	// serial half period in system cycles, kept above the two-cycle minimum
	localparam int HALF = 3;

	// serial clock stands low outside frames
	initial begin
		o_ser_clk = 1'b0;
		o_ser_data = 1'b0;
		o_latch = 1'b0;
	end

	// wait n system edges, then move just past the edge
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#2;
	endtask

	// one serial pulse; readout captured just before the fall
	task automatic pulse(input logic d, output logic q);
		o_ser_data = d;
		step(HALF);
		o_ser_clk = 1'b1;
		step(HALF);
		q = i_readback;
		o_ser_clk = 1'b0;
	endtask

	// whole word, lsb first, then latch pulse
	task automatic send_word(input logic [31:0] w);
		logic q;
		for (int k = 0; k < 32; k++) begin
			pulse(w[k], q);
		end
		// data line no longer carries the last bit
		o_ser_data = ~w[31];
		step(HALF);
		o_latch = 1'b1;
		step(2);
		o_latch = 1'b0;
		step(2);
	endtask

	// command write, one idle pulse, then 32 data pulses
	task automatic read_reg(input logic [2:0] sel, output logic [31:0] v);
		logic q;
		send_word({1'b1, sel, 23'h000000, 5'h08});
		pulse(1'b0, q);
		for (int k = 0; k < 32; k++) begin
			pulse(1'b0, q);
			v[k] = q;
		end
	endtask
endmodule

// File: sim/tb_serial_config_port_regs.sv
// self-checking bench for the serial configuration port
module tb_serial_config_port_regs;
	timeunit 1ns;
	timeprecision 100ps;
	// version code, value arbitrary
	localparam logic [1:0] ID_VAL = 2'h2;
	// expected detector codes per bandwidth setting
	localparam logic [31:0] DET_EXP [4] = '{32'h0, 32'h1, 32'h0, 32'h2};
	// fast gain cases: word, pins, effective gain
	localparam logic [31:0] FG_WORD [4] = '{32'h00018009, 32'h08018009,
		32'h18018009, 32'h18005009};
	localparam logic [2:0] FG_EXT [4] = '{3'h7, 3'h5, 3'h5, 3'h7};
	localparam logic [31:0] FG_EXP [4] = '{32'h18, 32'h13, 32'h0E, 32'h00};
	// words that must not land anywhere
	localparam logic [31:0] BAD_WORD [6] = '{32'hFFFFFFEC, 32'hFFFFFFE1, 32'hFFFFFFF1,
		32'hFFFFFFF9, 32'hFFFFFFEE, 32'h7FFFFFE8};
	logic i_clk, i_sys_rst, i_osc_clk, i_cmp_i_high, i_cmp_q_high, osc_run;
	logic [2:0] i_external_gain, trim;
	logic ser_clk, ser_data, latch, readback, mix_off, buf_off, filt_off, cal_off, attn, busy;
	logic [4:0] gain;
	logic [7:0] corner, i_code, q_code;
	logic [1:0] det_bw, iref;
	logic [31:0] reg3, reg5;
	int n_fail = 0;
	int cmp_count = 0;
	// offsets that the calibration has to find
	localparam logic [7:0] CAL_I = 8'h5C;
	localparam logic [7:0] CAL_Q = 8'hA3;

	// comparator stand-in: high while the applied code lies above the offset
	assign i_cmp_i_high = (i_code > CAL_I);
	assign i_cmp_q_high = (q_code > CAL_Q);

	scpr_port #(.ID_CODE(ID_VAL)) scpr_port_inst (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_ser_clk(ser_clk), .i_ser_data(ser_data), .i_latch_pulse_alt(latch),
		.o_readback(readback), .i_external_gain(i_external_gain),
		.i_osc_clk(i_osc_clk), .i_cmp_i_high(i_cmp_i_high), .i_cmp_q_high(i_cmp_q_high),
		.o_mixer_off(mix_off), .o_test_buffer_off(buf_off), .o_filter_off(filt_off),
		.o_cal_logic_off(cal_off), .o_gain_code(gain), .o_corner_code(corner),
		.o_det_bw(det_bw), .o_output_attenuator_enable(attn),
		.o_i_offset_code(i_code), .o_q_offset_code(q_code),
		.o_cal_reference_current_sel(iref), .o_osc_trim(trim), .o_cal_busy(busy),
		.o_mixer_load_filter_mode(reg3), .o_bias_trim_ctrl(reg5)
	);

	scpr_host_model scpr_host_model_inst (
		.i_clk(i_clk), .i_readback(readback),
		.o_ser_clk(ser_clk), .o_ser_data(ser_data), .o_latch(latch)
	);

	// 40 MHz system clock
	always #12.5 i_clk = ~i_clk;

	// free oscillator stand-in, only while enabled
	always begin
		repeat (4) @(posedge i_clk);
		#2;
		if (osc_run) begin
			i_osc_clk = ~i_osc_clk;
		end
	end

	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// readback of one register against an expected word
	task automatic rd_chk(input logic [2:0] sel, input logic [31:0] exp);
		logic [31:0] v;
		scpr_host_model_inst.read_reg(sel, v);
		check(v, exp);
	endtask

	// idle cycles, landing just past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#2;
	endtask

	task automatic test_done(input string name);
		$display("test %s done", name);
	endtask

	// verdict and end of run
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// hang guard, well above the expected run length
	initial begin
		repeat (40000) @(posedge i_clk);
		n_fail++;
		complete_run();
	end

	// main sequence
	initial begin
		i_clk = 1'b0;
		i_sys_rst = 1'b1;
		i_osc_clk = 1'b0;
		osc_run = 1'b0;
		i_external_gain = 3'h0;
		tick(2);
		i_sys_rst = 1'b0;
		tick(2);
		// power-up values
		check(32'({mix_off, buf_off, filt_off, cal_off, attn}), 32'h0A);
		check(32'(gain), 32'h0F);
		check(32'(corner), 32'h80);
		check(32'(det_bw), 32'h0);
		check(32'({i_code, q_code}), 32'h8080);
		check(32'({iref, trim}), 32'h1B);
		check(reg3, 32'h4000000B);
		check(reg5, 32'h0000AAAD);
		rd_chk(3'h1, 32'h0100FC89);
		rd_chk(3'h2, 32'h71E0200A);
		rd_chk(3'h0, 32'h80800048);
		test_done("defaults");
		// register 1 fields at their extremes
		scpr_host_model_inst.send_word(32'h83FF8129);
		check(32'({mix_off, buf_off, filt_off, cal_off, attn}), 32'h15);
		check(32'({gain, corner}), 32'h18FF);
		rd_chk(3'h1, 32'h83FF8129);
		for (int c = 0; c < 4; c++) begin
			scpr_host_model_inst.send_word(32'h00000009 | (32'(c) << 25));
			check(32'(det_bw), DET_EXP[c]);
		end
		check(32'({gain, corner}), 32'h0);
		test_done("register 1");
		// external gain pins, weight and floor
		for (int k = 0; k < 4; k++) begin
			i_external_gain = FG_EXT[k];
			scpr_host_model_inst.send_word(FG_WORD[k]);
			check(32'(gain), FG_EXP[k]);
		end
		i_external_gain = 3'h2;
		tick(3);
		check(32'(gain), 32'h01);
		i_external_gain = 3'h0;
		test_done("fast gain");
		// unused addresses and banks, then registers 3 and 5
		for (int k = 0; k < 6; k++) begin
			scpr_host_model_inst.send_word(BAD_WORD[k]);
		end
		rd_chk(3'h1, 32'h18005009);
		check(reg3, 32'h4000000B);
		check(reg5, 32'h0000AAAD);
		scpr_host_model_inst.send_word(32'hA5A5A5AB);
		scpr_host_model_inst.send_word(32'h5A5A5A4D);
		check(reg3, 32'hA5A5A5AB);
		check(reg5, 32'h5A5A5A4D);
		rd_chk(3'h3, 32'hA5A5A5AB);
		rd_chk(3'h5, 32'h5A5A5A4D);
		test_done("addressing");
		// manual codes, then one automatic run
		scpr_host_model_inst.send_word(32'hF0B28D4A);
		check(32'({i_code, q_code}), 32'h35CA);
		check(32'({iref, trim}), 32'h17);
		scpr_host_model_inst.send_word(32'hF1328D6A);
		osc_run = 1'b1;
		check(32'(busy), 32'h1);
		for (int w = 0; w < 1000 && busy !== 1'b0; w++) begin
			tick(1);
		end
		osc_run = 1'b0;
		check(32'(busy), 32'h0);
		check(32'({i_code, q_code}), {16'h0000, CAL_I, CAL_Q});
		rd_chk(3'h2, 32'hF1328D4A);
		rd_chk(3'h0, {CAL_I, CAL_Q, 16'h0048});
		test_done("calibration");
		// oscillator routed onto the readout pin
		scpr_host_model_inst.send_word(32'h20000009);
		for (int k = 0; k < 4; k++) begin
			i_osc_clk = ~i_osc_clk;
			tick(3);
			check(32'(readback), 32'(i_osc_clk));
		end
		test_done("oscillator test");
		complete_run();
	end
endmodule
